// ---- rtl/gtm_timer.sv ----
// How it works
// - one 16-bit counter: timer, synced counter or unsynced counter
// - interrupt on period match, and on gate falling edge when gated
// - run_enable bit 15 starts counting, clearing it stops
// - idle_stop bit 13 halts counting during Idle, else it continues
// - gate_accumulate_enable bit 6 gates internal clock; ignored on external
// - prescale_select bits 5-4: 1:256, 1:64, 1:8, 1:1
// - ext_clock_sync bit 2 picks synced or unsynced external clock
// - clock_source_select bit 1: external pin rising edge or internal
// - control write while running resets the prescale counter
// - unimplemented control bits ignore writes and read zero
// - counter may keep running in Idle and Sleep
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module gtm_timer
  import gtm_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic [GTM_AW-1:0] ADDR,
  input wire logic [GTM_DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [GTM_DW-1:0] RDATA,
  input wire logic IDLE_MODE,
  input wire logic SLEEP_MODE,
  input wire logic EXT_TIMER_CLOCK_PIN,
  output logic IRQ
);

  gtm_bus_req_t req;
  gtm_ctrl_t ctrl_ff;
  gtm_ctrl_t nxt_ctrl;
  logic [GTM_DW-1:0] count_ff;
  logic [GTM_DW-1:0] nxt_count;
  logic [GTM_DW-1:0] period_ff;
  logic [GTM_DW-1:0] nxt_period;
  logic [GTM_ST_W-1:0] status_ff;
  logic [GTM_ST_W-1:0] nxt_status;
  logic [GTM_ST_W-1:0] mask_ff;
  logic [GTM_ST_W-1:0] nxt_mask;
  logic [GTM_DW-1:0] rdata_ff;
  logic [GTM_DW-1:0] nxt_rdata;
  logic irq_ff;
  logic nxt_irq;
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_s3_ff;
  logic pin_s4_ff;
  logic tick;
  logic [GTM_PS_W-1:0] ps_cnt;

  assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

  // register decode
  wire logic ctrl_wr = req.wr && (req.addr == GTM_OFF_CTRL);
  wire logic count_wr = req.wr && (req.addr == GTM_OFF_COUNT);
  wire logic period_wr = req.wr && (req.addr == GTM_OFF_PERIOD);
  wire logic status_wr = req.wr && (req.addr == GTM_OFF_STATUS);
  wire logic mask_wr = req.wr && (req.addr == GTM_OFF_MASK);

  // control word as software sees it; reserved positions stay zero
  wire logic [GTM_DW-1:0] ctrl_word = {
    ctrl_ff.run, 1'b0, ctrl_ff.idle_stop, 6'h00, ctrl_ff.gate_en,
    ctrl_ff.ps, 1'b0, ctrl_ff.sync, ctrl_ff.cs, 1'b0};

  // only implemented positions are taken from a write
  assign nxt_ctrl = ctrl_wr ? '{
    run: req.wdata[GTM_BIT_RUN],
    idle_stop: req.wdata[GTM_BIT_IDLE],
    gate_en: req.wdata[GTM_BIT_GATE],
    ps: req.wdata[GTM_BIT_PS_HI:GTM_BIT_PS_LO],
    sync: req.wdata[GTM_BIT_SYNC],
    cs: req.wdata[GTM_BIT_CS]} : ctrl_ff;

  // pin synchroniser; s1 feeds s2 only
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
      pin_s4_ff <= 1'b0;
    end else begin
      pin_s1_ff <= EXT_TIMER_CLOCK_PIN;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_s4_ff <= pin_s3_ff;
    end
  end

  // unsynced path takes the earliest safe edge; the synced path
  // retimes once more so edges align with counter updates, one
  // cycle later. a true clockless path is not possible on one clock.
  wire logic edge_async = pin_s2_ff && !pin_s3_ff;
  wire logic edge_sync = pin_s3_ff && !pin_s4_ff;
  wire logic ext_edge = ctrl_ff.sync ? edge_sync : edge_async;
  wire logic gate_lvl = pin_s2_ff;
  wire logic gate_fall = pin_s3_ff && !pin_s2_ff;

  // only the unsynced external counter keeps going in Sleep
  wire logic sleep_ok = ctrl_ff.cs && !ctrl_ff.sync;
  wire logic hold = !ctrl_ff.run ||
                    (IDLE_MODE && ctrl_ff.idle_stop) ||
                    (SLEEP_MODE && !sleep_ok);
  wire logic gated = !ctrl_ff.cs && ctrl_ff.gate_en;
  wire logic int_in = !gated || gate_lvl;
  wire logic pre_in = !hold && (ctrl_ff.cs ? ext_edge : int_in);
  wire logic pre_clr = ctrl_wr && ctrl_ff.run;

  gtm_prescaler #(
    .W(GTM_PS_W)
  ) u_prescaler (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .clr(pre_clr),
    .tick_in(pre_in),
    .sel(ctrl_ff.ps),
    .tick_out(tick),
    .cnt(ps_cnt)
  );

  wire logic match_evt = tick && (count_ff == period_ff);
  wire logic gate_evt = gated && !hold && gate_fall;
  wire logic [GTM_ST_W-1:0] evt_vec = {gate_evt, match_evt};

  // wrap to zero on the tick that finds a match
  assign nxt_count = count_wr ? req.wdata :
                     !tick ? count_ff :
                     match_evt ? '0 :
                     count_ff + 16'h0001;
  assign nxt_period = period_wr ? req.wdata : period_ff;
  assign nxt_mask = mask_wr ? req.wdata[GTM_ST_W-1:0] : mask_ff;

  // write one to clear; a new event in the same cycle wins
  wire logic [GTM_ST_W-1:0] st_clr =
    status_wr ? req.wdata[GTM_ST_W-1:0] : '0;
  assign nxt_status = (status_ff & ~st_clr) | evt_vec;
  assign nxt_irq = |(nxt_status & nxt_mask);

  // unmapped reads return zero
  wire logic [GTM_DW-1:0] rd_mux =
    (req.addr == GTM_OFF_CTRL) ? ctrl_word :
    (req.addr == GTM_OFF_COUNT) ? count_ff :
    (req.addr == GTM_OFF_PERIOD) ? period_ff :
    (req.addr == GTM_OFF_STATUS) ? {14'h0000, status_ff} :
    (req.addr == GTM_OFF_MASK) ? {14'h0000, mask_ff} : 16'h0000;
  assign nxt_rdata = req.rd ? rd_mux : 16'h0000;

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_ff <= gtm_ctrl_t'(7'h00);
      count_ff <= GTM_RST_COUNT;
      period_ff <= GTM_RST_PERIOD;
    end else begin
      ctrl_ff <= nxt_ctrl;
      count_ff <= nxt_count;
      period_ff <= nxt_period;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status_ff <= GTM_RST_STATUS;
      mask_ff <= GTM_RST_MASK;
      irq_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  assign RDATA = rdata_ff;
  assign IRQ = irq_ff;

  // checks
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_ctrl_read;
    req.rd && (req.addr == GTM_OFF_CTRL);
  endsequence

  property p_ctrl_rsvd;
    s_ctrl_read |=> ((RDATA & ~GTM_CTRL_WMASK) == 16'h0000);
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd)
    else $error("reserved control bits read nonzero");

  property p_ctrl_echo;
    ctrl_wr ##1 s_ctrl_read |=>
      (RDATA == ($past(req.wdata, 2) & GTM_CTRL_WMASK));
  endproperty
  a_ctrl_echo: assert property (p_ctrl_echo)
    else $error("control readback differs from written fields");

  property p_stopped;
    (!ctrl_ff.run && !count_wr) |=> (count_ff == $past(count_ff));
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("count moved while stopped");

  property p_idle_stop;
    (IDLE_MODE && ctrl_ff.idle_stop && !count_wr) |=>
      $stable(count_ff);
  endproperty
  a_idle_stop: assert property (p_idle_stop)
    else $error("count moved in idle with idle_stop set");

  property p_sleep;
    (SLEEP_MODE && !sleep_ok && !count_wr) |=> $stable(count_ff);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("count moved in sleep on a clock that stops");

  property p_match_wrap;
    (match_evt && !count_wr) |=>
      (count_ff == 16'h0000) && status_ff[GTM_ST_MATCH];
  endproperty
  a_match_wrap: assert property (p_match_wrap)
    else $error("period match did not wrap count and set flag");

  property p_count_step;
    (tick && !match_evt && !count_wr) |=>
      (count_ff == $past(count_ff) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not step by one on a tick");

  property p_gate_block;
    (tick && gated) |-> gate_lvl;
  endproperty
  a_gate_block: assert property (p_gate_block)
    else $error("gated count ticked with gate low");

  property p_gate_irq;
    (gated && ctrl_ff.run && !hold && pin_s3_ff && !pin_s2_ff) |=>
      status_ff[GTM_ST_GATE];
  endproperty
  a_gate_irq: assert property (p_gate_irq)
    else $error("gate falling edge did not set flag");

  property p_no_gate_ext;
    ctrl_ff.cs |=> !($rose(status_ff[GTM_ST_GATE]));
  endproperty
  a_no_gate_ext: assert property (p_no_gate_ext)
    else $error("gate flag set with external clock selected");

  property p_ps_one;
    (pre_in && !pre_clr && ctrl_ff.ps == GTM_PS_1) |-> tick;
  endproperty
  a_ps_one: assert property (p_ps_one)
    else $error("1:1 prescale missed a tick");

  property p_ps_eight;
    (tick && ctrl_ff.ps == GTM_PS_8 && !ctrl_wr) |=> (!tick) [*7];
  endproperty
  a_ps_eight: assert property (p_ps_eight)
    else $error("1:8 prescale ticked early");

  property p_ps_clr;
    (ctrl_wr && ctrl_ff.run) |=> (ps_cnt == 8'h00);
  endproperty
  a_ps_clr: assert property (p_ps_clr)
    else $error("prescaler not reset by control write while running");

  sequence s_pin_rise;
    pin_s2_ff && !pin_s3_ff;
  endsequence

  property p_sync_edge;
    (ctrl_ff.cs && ctrl_ff.sync && !ctrl_wr) ##0 s_pin_rise |=>
      ext_edge;
  endproperty
  a_sync_edge: assert property (p_sync_edge)
    else $error("synced edge not seen one cycle after raw edge");

  property p_async_edge;
    (ctrl_ff.cs && !ctrl_ff.sync) |-> (ext_edge == edge_async);
  endproperty
  a_async_edge: assert property (p_async_edge)
    else $error("unsynced path edge mismatch");

  property p_int_src;
    (!hold && !ctrl_ff.cs && !gated) |-> pre_in;
  endproperty
  a_int_src: assert property (p_int_src)
    else $error("internal clock not fed to prescaler");

  property p_set_wins;
    (match_evt && status_wr && req.wdata[GTM_ST_MATCH]) |=>
      status_ff[GTM_ST_MATCH];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("match lost to a same-cycle clear");

  property p_irq_out;
    (|(status_ff & mask_ff)) && !status_wr && !mask_wr |=> IRQ;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("irq low with unmasked status set");

  property p_read_once;
    !req.rd |=> (RDATA == 16'h0000);
  endproperty
  a_read_once: assert property (p_read_once)
    else $error("read data outside its one cycle");

  property p_count_load;
    count_wr |=> (count_ff == $past(req.wdata));
  endproperty
  a_count_load: assert property (p_count_load)
    else $error("count write did not load the count");

  property p_ps_sixtyfour;
    (tick && ctrl_ff.ps == GTM_PS_64 && !ctrl_wr) |=> (!tick) [*8];
  endproperty
  a_ps_sixtyfour: assert property (p_ps_sixtyfour)
    else $error("1:64 prescale ticked early");

  property p_ctrl_keep;
    !ctrl_wr |=> $stable(ctrl_word);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep)
    else $error("control changed without a write");

  property p_status_clr;
    (status_wr && req.wdata[GTM_ST_MATCH] && !match_evt) |=>
      !status_ff[GTM_ST_MATCH];
  endproperty
  a_status_clr: assert property (p_status_clr)
    else $error("match flag not cleared by writing one");

  property p_irq_quiet;
    !(|(status_ff & mask_ff)) && !(|evt_vec) && !mask_wr |=> !IRQ;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("irq high with no unmasked status set");

endmodule

// ---- rtl/gtm_pkg.sv ----
package gtm_pkg;

  localparam int unsigned GTM_AW = 4;
  localparam int unsigned GTM_DW = 16;
  localparam int unsigned GTM_PS_W = 8;
  localparam int unsigned GTM_ST_W = 2;

  // register offsets on the plain port
  localparam logic [GTM_AW-1:0] GTM_OFF_CTRL = 4'h0;
  localparam logic [GTM_AW-1:0] GTM_OFF_COUNT = 4'h2;
  localparam logic [GTM_AW-1:0] GTM_OFF_PERIOD = 4'h4;
  localparam logic [GTM_AW-1:0] GTM_OFF_STATUS = 4'h6;
  localparam logic [GTM_AW-1:0] GTM_OFF_MASK = 4'h8;

  // control field positions
  localparam int unsigned GTM_BIT_RUN = 15;
  localparam int unsigned GTM_BIT_IDLE = 13;
  localparam int unsigned GTM_BIT_GATE = 6;
  localparam int unsigned GTM_BIT_PS_HI = 5;
  localparam int unsigned GTM_BIT_PS_LO = 4;
  localparam int unsigned GTM_BIT_SYNC = 2;
  localparam int unsigned GTM_BIT_CS = 1;
  localparam logic [GTM_DW-1:0] GTM_CTRL_WMASK = 16'hA076;

  // status bit positions
  localparam int unsigned GTM_ST_MATCH = 0;
  localparam int unsigned GTM_ST_GATE = 1;

  // reset values
  localparam logic [GTM_DW-1:0] GTM_RST_CTRL = 16'h0000;
  localparam logic [GTM_DW-1:0] GTM_RST_COUNT = 16'h0000;
  localparam logic [GTM_DW-1:0] GTM_RST_PERIOD = 16'hFFFF;
  localparam logic [GTM_ST_W-1:0] GTM_RST_STATUS = 2'h0;
  localparam logic [GTM_ST_W-1:0] GTM_RST_MASK = 2'h0;

  // prescale codes and terminal counts (ratio minus one)
  localparam logic [1:0] GTM_PS_1 = 2'h0;
  localparam logic [1:0] GTM_PS_8 = 2'h1;
  localparam logic [1:0] GTM_PS_64 = 2'h2;
  localparam logic [1:0] GTM_PS_256 = 2'h3;
  localparam logic [GTM_PS_W-1:0] GTM_TERM_1 = 8'h00;
  localparam logic [GTM_PS_W-1:0] GTM_TERM_8 = 8'h07;
  localparam logic [GTM_PS_W-1:0] GTM_TERM_64 = 8'h3F;
  localparam logic [GTM_PS_W-1:0] GTM_TERM_256 = 8'hFF;

  typedef struct packed {
    logic run;
    logic idle_stop;
    logic gate_en;
    logic [1:0] ps;
    logic sync;
    logic cs;
  } gtm_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [GTM_AW-1:0] addr;
    logic [GTM_DW-1:0] wdata;
  } gtm_bus_req_t;

endpackage

// ---- rtl/gtm_prescaler.sv ----
`timescale 1ns/100ps
module gtm_prescaler
  import gtm_pkg::*;
#(
  parameter int unsigned W = GTM_PS_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clr,
  input wire logic tick_in,
  input wire logic [1:0] sel,
  output logic tick_out,
  output logic [W-1:0] cnt
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  wire logic [W-1:0] term;
  wire logic at_term;

  assign term = (sel == GTM_PS_256) ? W'(GTM_TERM_256) :
                (sel == GTM_PS_64)  ? W'(GTM_TERM_64) :
                (sel == GTM_PS_8)   ? W'(GTM_TERM_8) : W'(GTM_TERM_1);
  assign at_term = (cnt_ff >= term);
  assign tick_out = tick_in && at_term && !clr;
  assign cnt = cnt_ff;

  // clear wins over a pending input edge
  assign nxt_cnt = clr ? '0 :
                   !tick_in ? cnt_ff :
                   at_term ? '0 : cnt_ff + W'(1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// ---- tb/gtm_pin_model.sv ----
`timescale 1ns/100ps
// drives the external clock / gate pin; low whenever no burst or hold runs
module gtm_pin_model (
  output logic pin
);
  initial pin = 1'b0;

  // odd start offset keeps edges away from the core clock edge
  task automatic pulses(input int n, input int hw);
    #17;
    repeat (n) begin
      #(hw) pin = 1'b1;
      #(hw) pin = 1'b0;
    end
  endtask

  task automatic hold(input int t);
    #17 pin = 1'b1;
    #(t) pin = 1'b0;
  endtask
endmodule

// ---- tb/gtm_timer_test.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module gtm_timer_test;
  import gtm_pkg::*;
  localparam logic [15:0] c_run = 16'h8000;
  localparam logic [15:0] c_idle = 16'h2000;
  localparam logic [15:0] c_gate = 16'h0040;
  localparam logic [15:0] c_sync = 16'h0004;
  localparam logic [15:0] c_ext = 16'h0002;
  logic CORE_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [GTM_AW-1:0] ADDR = 4'h0;
  logic [GTM_DW-1:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic IDLE_MODE = 1'b0;
  logic SLEEP_MODE = 1'b0;
  logic [GTM_DW-1:0] RDATA;
  logic EXT;
  logic IRQ;
  logic [15:0] v;
  logic [15:0] c0;
  int n_errors = 0;
  int n_checks = 0;

  gtm_timer DUT (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IDLE_MODE(IDLE_MODE),
    .SLEEP_MODE(SLEEP_MODE), .EXT_TIMER_CLOCK_PIN(EXT), .IRQ(IRQ));
  gtm_pin_model u_pin (.pin(EXT));

  always #50 CORE_CLK = ~CORE_CLK;

  task tk(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  // leading edge gives a gap, so strobes never get two drives at once
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task results;
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task t_reset;
    rd(GTM_OFF_CTRL, v); `CHK(v, 16'h0000)
    rd(GTM_OFF_COUNT, v); `CHK(v, 16'h0000)
    rd(GTM_OFF_PERIOD, v); `CHK(v, 16'hFFFF)
    rd(GTM_OFF_STATUS, v); `CHK(v, 16'h0000)
    rd(GTM_OFF_MASK, v); `CHK(v, 16'h0000)
    rd(4'hE, v); `CHK(v, 16'h0000)
    `CHK(IRQ, 1'b0)
    wr(GTM_OFF_CTRL, 16'hFFFF);
    rd(GTM_OFF_CTRL, v); `CHK(v, 16'hA076)
    wr(GTM_OFF_CTRL, 16'h0000);
  endtask

  task t_presc;
    int r;
    for (int k = 0; k < 4; k++) begin
      r = (k == 0) ? 1 : (k == 1) ? 8 : (k == 2) ? 64 : 256;
      wr(GTM_OFF_COUNT, 16'h0000);
      wr(GTM_OFF_CTRL, c_run | 16'(k << 4));
      wr(GTM_OFF_CTRL, c_run | 16'(k << 4));
      tk(510);
      wr(GTM_OFF_CTRL, 16'(k << 4));
      rd(GTM_OFF_COUNT, v);
      `CHK(int'(v) >= 512 / r - 1 && int'(v) <= 512 / r + 3, 1'b1)
    end
  endtask

  task t_match;
    wr(GTM_OFF_PERIOD, 16'h0005);
    wr(GTM_OFF_MASK, 16'h0001);
    wr(GTM_OFF_COUNT, 16'h0000);
    wr(GTM_OFF_CTRL, c_run);
    for (int i = 0; i < 20 && IRQ !== 1'b1; i++) @(posedge CORE_CLK);
    `CHK(IRQ, 1'b1)
    tk(37);
    rd(GTM_OFF_COUNT, v); `CHK(v <= 16'h0005, 1'b1)
    wr(GTM_OFF_CTRL, 16'h0000);
    rd(GTM_OFF_STATUS, v); `CHK(v, 16'h0001)
    wr(GTM_OFF_STATUS, 16'h0001);
    tk(2); `CHK(IRQ, 1'b0)
    wr(GTM_OFF_MASK, 16'h0000);
    wr(GTM_OFF_CTRL, c_run);
    tk(20);
    wr(GTM_OFF_CTRL, 16'h0000);
    tk(2); `CHK(IRQ, 1'b0)
    wr(GTM_OFF_MASK, 16'h0001);
    tk(2); `CHK(IRQ, 1'b1)
    wr(GTM_OFF_STATUS, 16'h0003);
    wr(GTM_OFF_MASK, 16'h0000);
    wr(GTM_OFF_PERIOD, 16'hFFFF);
  endtask

  task t_idle;
    wr(GTM_OFF_COUNT, 16'h0000);
    wr(GTM_OFF_CTRL, c_run | c_idle);
    IDLE_MODE <= 1'b1;
    tk(3);
    rd(GTM_OFF_COUNT, c0);
    tk(20);
    rd(GTM_OFF_COUNT, v); `CHK(v, c0)
    wr(GTM_OFF_CTRL, c_run);
    tk(20);
    rd(GTM_OFF_COUNT, v); `CHK(v > c0 + 16'd19, 1'b1)
    IDLE_MODE <= 1'b0;
    wr(GTM_OFF_CTRL, 16'h0000);
  endtask

  // gate bit set too: with an external source it must change nothing
  task t_ext;
    for (int s = 0; s < 2; s++) begin
      wr(GTM_OFF_COUNT, 16'h0000);
      wr(GTM_OFF_CTRL, c_run | c_ext | c_gate | (s ? c_sync : 16'h0000));
      u_pin.pulses(10, 300);
      tk(6);
      rd(GTM_OFF_COUNT, v); `CHK(v, 16'h000A)
    end
    wr(GTM_OFF_CTRL, c_run | c_ext);
    SLEEP_MODE <= 1'b1;
    u_pin.pulses(4, 300);
    tk(6);
    rd(GTM_OFF_COUNT, v); `CHK(v, 16'h000E)
    SLEEP_MODE <= 1'b0;
    wr(GTM_OFF_CTRL, 16'h0000);
  endtask

  task t_gate;
    wr(GTM_OFF_MASK, 16'h0002);
    wr(GTM_OFF_COUNT, 16'h0000);
    wr(GTM_OFF_CTRL, c_run | c_gate);
    tk(20);
    rd(GTM_OFF_COUNT, v); `CHK(v, 16'h0000)
    `CHK(IRQ, 1'b0)
    u_pin.hold(3000);
    tk(6);
    rd(GTM_OFF_COUNT, v); `CHK(v >= 16'd28 && v <= 16'd32, 1'b1)
    rd(GTM_OFF_STATUS, v); `CHK(v, 16'h0002)
    `CHK(IRQ, 1'b1)
    wr(GTM_OFF_CTRL, 16'h0000);
    wr(GTM_OFF_STATUS, 16'h0003);
  endtask

  initial begin
    tk(5);
    ARST_N <= 1'b1;
    t_reset;
    t_presc;
    t_match;
    t_idle;
    t_ext;
    t_gate;
    results;
  end

  // whole run is a few thousand cycles; three milliseconds is ample
  initial begin
    #3000000;
    n_errors++;
    results;
  end
endmodule
